// file: rtl/nrs_host.sv
// Host sequencer: drives NAND read, random read, cache read and identifier flows
module nrs_host
    import nrs_pkg::*;
#(
    parameter int COL_W   = 12,
    parameter int ROW_W   = 24,
    parameter int COUNT_W = 12
) (
    input  wire logic        i_clk_sys,   // System clock 25 MHz
    input  wire logic        i_srst,      // Synchronous reset, active high
    input  wire logic [3:0]  i_addr,      // Register address
    input  wire logic [31:0] i_wdata,     // Write data
    input  wire logic        i_wr,        // Write strobe
    input  wire logic        i_rd,        // Read strobe
    output logic      [31:0] o_rdata,     // Read data, one cycle after strobe
    output logic             o_chip_en_n, // Chip enable, low active
    output logic             o_cmd_latch, // Command latch enable
    output logic             o_addr_latch,// Address latch enable
    output logic             o_write_n,   // Write strobe pin, low active
    output logic             o_read_strobe_n, // Read strobe pin, low active
    output logic       [7:0] o_io,        // Data bus out
    output logic             o_io_oe_n,   // Data bus drive enable, low drives
    input  wire logic  [7:0] i_io,        // Data bus in
    input  wire logic        i_ready      // Ready/busy pin, high ready
);
    if (COL_W < 8 || COL_W > 16 || ROW_W < 8 || ROW_W > 24 || COUNT_W < 1 || COUNT_W > 16) begin : g_bad_param
        $error("nrs_host parameter out of range");
    end
    nrs_state_t        state;
    logic [2:0]        cmd;
    logic [COL_W-1:0]  col;
    logic [ROW_W-1:0]  row;
    logic [COUNT_W-1:0] count, left;
    logic [2:0]        acnt;
    logic              busy, dvalid, done, err;
    logic [7:0]        data;
    logic [39:0]       ident;
    logic [7:0]        wb_cnt;
    logic              stb_go, stb_low, stb_done;
    logic              rd_go, rd_low, rd_done;
    logic [7:0]        wbyte;
    // Address byte for the given cycle index
    function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [COL_W-1:0] c,
                                             input logic [ROW_W-1:0] r);
        logic [15:0] cw;
        logic [23:0] rw;
        cw = 16'(c);
        rw = 24'(r);
        case (i)
            3'h0:    addr_byte = cw[7:0];
            3'h1:    addr_byte = cw[15:8];
            3'h2:    addr_byte = rw[7:0];
            3'h3:    addr_byte = rw[15:8];
            default: addr_byte = rw[23:16];
        endcase
    endfunction : addr_byte
    // Number of address cycles each host command needs
    function automatic logic [2:0] addr_cycles(input logic [2:0] c);
        case (c)
            HC_PAGE_READ: addr_cycles = 3'(PAGE_ADDR_CYC);
            HC_RAND_READ: addr_cycles = 3'(COL_ADDR_CYC);
            HC_IDENT:     addr_cycles = 3'h1;
            default:      addr_cycles = 3'h0;
        endcase
    endfunction : addr_cycles
    // First opcode of each host command
    function automatic logic [7:0] first_op(input logic [2:0] c);
        case (c)
            HC_PAGE_READ:  first_op = OP_READ;
            HC_RAND_READ:  first_op = OP_RAND;
            HC_CACHE_NEXT: first_op = OP_CACHE_NEXT;
            HC_CACHE_LAST: first_op = OP_CACHE_LAST;
            HC_IDENT:      first_op = OP_IDENT;
            default:       first_op = OP_STATUS;
        endcase
    endfunction : first_op
    // ------------------------------------------------------------------------
    // Pin strobe timers
    // ------------------------------------------------------------------------
    nrs_strobe #(.LOW_CYC(SETUP_CYC)) u_wr_stb (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_start   (stb_go),
        .o_low     (stb_low),
        .o_done    (stb_done)
    );
    nrs_strobe #(.LOW_CYC(SETUP_CYC)) u_rd_stb (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_start   (rd_go),
        .o_low     (rd_low),
        .o_done    (rd_done)
    );
    assign stb_go = (state == NRS_CMD1 || state == NRS_ADDR || state == NRS_CMD2 || state == NRS_REREAD)
                    && !stb_low && !stb_done;
    assign rd_go  = ((state == NRS_READ && left != '0) || state == NRS_POLL) && !rd_low && !rd_done;
    // Byte placed on the bus in each write phase
    always_comb begin
        case (state)
            NRS_CMD1:   wbyte = first_op(cmd);
            NRS_ADDR:   wbyte = (cmd == HC_IDENT) ? 8'h00 : addr_byte(acnt, col, row);
            NRS_CMD2:   wbyte = (cmd == HC_PAGE_READ) ? OP_READ_CONF : OP_RAND_CONF;
            NRS_REREAD: wbyte = OP_READ;
            default:    wbyte = 8'h00;
        endcase
    end
    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state <= NRS_IDLE;
            acnt  <= 3'h0;
            left  <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
            err   <= 1'b0;
            dvalid <= 1'b0;
            data  <= 8'h00;
            ident <= 40'h0;
            wb_cnt <= 8'h00;
        end else begin
            if (i_rd && i_addr == REG_DATA) dvalid <= 1'b0;
            if (i_wr && i_addr == REG_STATUS) begin
                done <= 1'b0;
                err  <= 1'b0;
            end
            case (state)
                NRS_IDLE: begin
                    if (i_wr && i_addr == REG_CMD) begin
                        // Cache commands need the ready pin high first
                        if ((i_wdata[2:0] == HC_CACHE_NEXT || i_wdata[2:0] == HC_CACHE_LAST) && !i_ready) begin
                            err <= 1'b1;
                        end else if (i_wdata[2:0] >= HC_PAGE_READ && i_wdata[2:0] <= HC_STATUS_POLL) begin
                            state <= NRS_CMD1;
                            busy  <= 1'b1;
                            acnt  <= 3'h0;
                        end else begin
                            err <= 1'b1;
                        end
                    end
                end
                NRS_CMD1: if (stb_done) begin
                    if (addr_cycles(cmd) != 3'h0) state <= NRS_ADDR;
                    else if (cmd == HC_STATUS_POLL) state <= NRS_POLL;
                    else begin
                        state  <= NRS_WAIT_WB;
                        wb_cnt <= 8'(WB_CYC);
                    end
                end
                NRS_ADDR: if (stb_done) begin
                    acnt <= acnt + 3'h1;
                    if (acnt + 3'h1 == addr_cycles(cmd)) begin
                        state <= (cmd == HC_IDENT) ? NRS_READ : NRS_CMD2;
                        left  <= (cmd == HC_IDENT) ? COUNT_W'(IDENT_BYTES) : count;
                    end
                end
                NRS_CMD2: if (stb_done) begin
                    if (cmd == HC_PAGE_READ) begin
                        state  <= NRS_WAIT_WB;
                        wb_cnt <= 8'(WB_CYC);
                    end else begin
                        state <= NRS_READ;
                        left  <= count;
                    end
                end
                NRS_WAIT_WB: begin
                    if (wb_cnt != 8'h00) wb_cnt <= wb_cnt - 8'h01;
                    else state <= NRS_WAIT_RDY;
                end
                NRS_WAIT_RDY: if (i_ready) begin
                    // Page data ready in data or cache register; read it out
                    state <= (cmd == HC_PAGE_READ) ? NRS_READ : NRS_READ;
                    left  <= count;
                end
                NRS_REREAD: if (stb_done) begin
                    state <= NRS_READ;
                    left  <= count;
                end
                NRS_POLL: if (rd_done) begin
                    data   <= i_io;
                    dvalid <= 1'b1;
                    if (i_io[SR_READY_BIT]) state <= NRS_REREAD;
                end
                NRS_READ: begin
                    if (left == '0) begin
                        state <= NRS_IDLE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                    end else if (rd_done) begin
                        data   <= i_io;
                        dvalid <= 1'b1;
                        left   <= left - COUNT_W'(1);
                        if (cmd == HC_IDENT) ident <= {i_io, ident[39:8]};
                    end
                end
                default: state <= NRS_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cmd   <= HC_PAGE_READ;
            col   <= '0;
            row   <= '0;
            count <= '0;
        end else if (i_wr) begin
            case (i_addr)
                REG_CMD:   if (state == NRS_IDLE) cmd <= i_wdata[2:0];
                REG_COL:   col   <= i_wdata[COL_W-1:0];
                REG_ROW:   row   <= i_wdata[ROW_W-1:0];
                REG_COUNT: count <= i_wdata[COUNT_W-1:0];
                default:   ;
            endcase
        end
    end
    // Read data register, valid the cycle after the read strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) o_rdata <= 32'h0;
        else if (i_rd) begin
            case (i_addr)
                REG_CMD:      o_rdata <= {29'h0, cmd};
                REG_COL:      o_rdata <= 32'(col);
                REG_ROW:      o_rdata <= 32'(row);
                REG_COUNT:    o_rdata <= 32'(count);
                REG_STATUS:   o_rdata <= {27'h0, err, done, i_ready, dvalid, busy};
                REG_DATA:     o_rdata <= {24'h0, data};
                REG_IDENT_LO: o_rdata <= ident[31:0];
                REG_IDENT_HI: o_rdata <= {24'h0, ident[39:32]};
                default:      o_rdata <= 32'h0;
            endcase
        end
    end
    // ------------------------------------------------------------------------
    // Pin drivers, registered; memory starts in read mode so none at reset
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_chip_en_n     <= 1'b1;
            o_cmd_latch     <= 1'b0;
            o_addr_latch    <= 1'b0;
            o_write_n       <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_io            <= 8'h00;
            o_io_oe_n       <= 1'b1;
        end else begin
            o_chip_en_n     <= (state == NRS_IDLE);
            o_cmd_latch     <= (state == NRS_CMD1 || state == NRS_CMD2 || state == NRS_REREAD);
            o_addr_latch    <= (state == NRS_ADDR);
            o_write_n       <= !(stb_go || (stb_low && !stb_done));
            o_read_strobe_n <= !(rd_go || (rd_low && !rd_done));
            o_io            <= wbyte;
            o_io_oe_n       <= !(state == NRS_CMD1 || state == NRS_ADDR || state == NRS_CMD2 || state == NRS_REREAD);
        end
    end
endmodule : nrs_host

// file: rtl/nrs_pkg.sv
// Package: constants for the NAND read-path host sequencer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package nrs_pkg;
    // Flash opcodes
    localparam logic [7:0] OP_READ        = 8'h00;
    localparam logic [7:0] OP_READ_CONF   = 8'h30;
    localparam logic [7:0] OP_CACHE_NEXT  = 8'h31;
    localparam logic [7:0] OP_CACHE_LAST  = 8'h3f;
    localparam logic [7:0] OP_RAND        = 8'h05;
    localparam logic [7:0] OP_RAND_CONF   = 8'he0;
    localparam logic [7:0] OP_IDENT       = 8'h90;
    localparam logic [7:0] OP_STATUS      = 8'h70;
    // Address cycle counts and identifier byte count
    localparam int         PAGE_ADDR_CYC  = 5;
    localparam int         COL_ADDR_CYC   = 2;
    localparam int         IDENT_BYTES    = 5;
    // Status register ready bit
    localparam int         SR_READY_BIT   = 6;
    // Host command codes written to the command register
    localparam logic [2:0] HC_PAGE_READ   = 3'h1;
    localparam logic [2:0] HC_RAND_READ   = 3'h2;
    localparam logic [2:0] HC_CACHE_NEXT  = 3'h3;
    localparam logic [2:0] HC_CACHE_LAST  = 3'h4;
    localparam logic [2:0] HC_IDENT       = 3'h5;
    localparam logic [2:0] HC_STATUS_POLL = 3'h6;
    // Host register offsets
    localparam logic [3:0] REG_CMD        = 4'h0;
    localparam logic [3:0] REG_COL        = 4'h1;
    localparam logic [3:0] REG_ROW        = 4'h2;
    localparam logic [3:0] REG_COUNT      = 4'h3;
    localparam logic [3:0] REG_STATUS     = 4'h4;
    localparam logic [3:0] REG_DATA       = 4'h5;
    localparam logic [3:0] REG_IDENT_LO   = 4'h6;
    localparam logic [3:0] REG_IDENT_HI   = 4'h7;
    // Status register bit positions
    localparam int         ST_BUSY        = 0;
    localparam int         ST_DATA_VALID  = 1;
    localparam int         ST_READY_PIN   = 2;
    localparam int         ST_DONE        = 3;
    localparam int         ST_ERROR       = 4;
    // Pin timing, in ns, and cycle counts at 25 MHz
    localparam int         CLK_PERIOD_NS  = 40;
    localparam int         SETUP_NS       = 20;
    localparam int         SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         WB_NS          = 100;
    localparam int         WB_CYC         = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Host sequencer states
    typedef enum logic [3:0] {
        NRS_IDLE, NRS_CMD1, NRS_ADDR, NRS_CMD2, NRS_WAIT_WB, NRS_WAIT_RDY,
        NRS_REREAD, NRS_READ, NRS_POLL
    } nrs_state_t;
endpackage : nrs_pkg

// file: rtl/nrs_strobe.sv
// Strobe timer: produces pin strobe pulses of a fixed low time
module nrs_strobe
    import nrs_pkg::*;
#(
    parameter int LOW_CYC = 1
) (
    input  wire logic i_clk_sys, // System clock
    input  wire logic i_srst,    // Synchronous reset
    input  wire logic i_start,   // Begin one strobe
    output logic      o_low,     // Strobe held low
    output logic      o_done     // High in the last low cycle
);
    if (LOW_CYC < 1 || LOW_CYC > 255) begin : g_bad_low
        $error("LOW_CYC out of range");
    end
    logic [7:0] cnt;
    // ------------------------------------------------------------------------
    // Count low period; done marks its last cycle so the pin can mirror o_low
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cnt    <= 8'h00;
            o_low  <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start && !o_low) begin
                o_low  <= 1'b1;
                o_done <= (LOW_CYC == 1);
                cnt    <= 8'(LOW_CYC);
            end else if (o_low) begin
                if (cnt == 8'h01) o_low <= 1'b0;
                else o_done <= (cnt == 8'h02);
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : nrs_strobe

// file: testbench/nrs_flash_model.sv
// Behavioural flash memory answering the sequencer's pins
module nrs_flash_model #(
    parameter int         LOAD   = 40,    // Array load busy, ticks
    parameter int         COPY   = 4,     // Cache copy busy, ticks
    parameter logic [7:0] MAKER  = 8'h5a, // Arbitrary maker code
    parameter logic [7:0] DEVICE = 8'ha7  // Arbitrary device code
) (
    input  wire logic       i_tick,          // Internal timebase
    input  wire logic       i_ce_n,          // Chip enable, low active
    input  wire logic       i_cle,           // Command latch
    input  wire logic       i_ale,           // Address latch
    input  wire logic       i_we_n,          // Write pin, low active
    input  wire logic       i_read_strobe_n, // Read pin, low active
    input  wire logic [7:0] i_io,            // Bus from host
    output logic      [7:0] o_io,            // Bus to host
    output logic            o_ready          // Ready, high ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  ab [5];           // Address bytes
    logic [7:0]  idt [5];          // Identifier table
    logic [7:0]  cur;              // Byte under the pointer
    logic [1:0]  mode = 2'd0;      // Read mode at power-up
    logic [11:0] pcol = '0;        // Column of the page read
    logic [11:0] col = '0;         // Column pointer
    logic [23:0] drow = '0;        // Row in the data register
    logic [23:0] orow = '0;        // Row being output
    logic        pre = 1'b1;       // Read pin at last tick
    int          na = 0;
    int          busy = 0;
    int          fetch = 0;
    assign idt = '{MAKER, DEVICE, 8'h90, 8'h95, 8'h54}; // One die section
    assign o_ready = (busy == 0);
    // Released bus shows the inverse, never a stale byte
    assign o_io = (!i_ce_n && !i_read_strobe_n) ? cur : ~cur;
    // Byte for the current mode
    always_comb begin
        if (mode == 2'd1) cur = {1'b1, o_ready, o_ready, 5'h00}; // Status until a new opcode
        else if (mode == 2'd2) cur = (col < 12'h5) ? idt[col[2:0]] : 8'h00;
        else cur = orow[7:0] ^ col[7:0] ^ {col[11:8], orow[11:8]}; // Cache readable during fetch
    end
    // Pins sampled mid-cycle
    always @(negedge i_tick) begin
        pre <= i_read_strobe_n;
        busy <= (busy > 0) ? busy - 1 : 0;
        fetch <= (fetch > 0) ? fetch - 1 : 0;
        if (!i_ce_n && !pre && i_read_strobe_n) col <= col + 12'h1; // Next byte per strobe
        if (!i_ce_n && !i_we_n && i_ale && na < 5) begin
            ab[na] <= i_io;
            na <= na + 1;
        end
        if (!i_ce_n && !i_we_n && i_cle) begin
            na <= 0;
            mode <= 2'd0;
            case (i_io)
                8'h00: col <= pcol; // Restart at first column
                8'h30: begin
                    pcol <= {ab[1][3:0], ab[0]};
                    col <= {ab[1][3:0], ab[0]};
                    orow <= {ab[4], ab[3], ab[2]};
                    drow <= {ab[4], ab[3], ab[2]};
                    busy <= LOAD;
                end
                8'he0: col <= {ab[1][3:0], ab[0]}; // New column in the page
                8'h31, 8'h3f: begin
                    orow <= drow;
                    col <= '0;
                    busy <= COPY + fetch; // Pending fetch must end first
                    if (i_io == 8'h31) begin
                        drow <= drow + 24'h1; // Last-page opcode starts no fetch
                        fetch <= COPY + fetch + LOAD;
                    end
                end
                8'h70: mode <= 2'd1;
                8'h90: begin
                    mode <= 2'd2;
                    col <= '0;
                end
                default: ;
            endcase
        end
    end
endmodule : nrs_flash_model

// file: testbench/nrs_host_bench.sv
// Bench: read sequencer against a behavioural flash model
module nrs_host_bench
    import nrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h5a;  // Arbitrary maker code
    localparam logic [7:0] DEVICE = 8'ha7; // Arbitrary device code
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = '0, rdata, s;
    logic        ce_n, cle, ale, we_n, re_n, oe_n, rdy;
    logic [7:0]  io_h, io_m, cnt;
    logic [9:0]  log_q[$], exp_q[$];
    logic [23:0] row;
    logic [11:0] col, pc;
    int          bad_count = 0, n_compared = 0, nre = 0;
    nrs_host i_nrs_host (.i_clk_sys(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_chip_en_n(ce_n), .o_cmd_latch(cle), .o_addr_latch(ale), .o_write_n(we_n),
        .o_read_strobe_n(re_n), .o_io(io_h), .o_io_oe_n(oe_n), .i_io(io_m), .i_ready(rdy));
    nrs_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) i_nrs_flash_model (.i_tick(clk), .i_ce_n(ce_n),
        .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_read_strobe_n(re_n), .i_io(io_h), .o_io(io_m), .o_ready(rdy));
    initial forever #20 clk = ~clk;
    // Log pin writes and count read strobes
    always @(negedge clk) begin
        if (!we_n) log_q.push_back({cle, ale, io_h});
        if (!re_n) nre++;
    end
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic logic [7:0] pat(input logic [23:0] r, input logic [11:0] c);
        return r[7:0] ^ c[7:0] ^ {c[11:8], r[11:8]};
    endfunction : pat
    task automatic run(input logic [2:0] code);
        log_q.delete();
        nre = 0;
        s = '0;
        wr_reg(REG_CMD, {29'h0, code});
        for (int k = 0; k < 3000 && s[ST_DONE] !== 1'b1; k++) rd_reg(REG_STATUS, s);
        check(s[ST_DONE], 1'b1);
        wr_reg(REG_STATUS, 32'h0);
    endtask : run
    task automatic cmp_log;
        check(32'(log_q.size()), 32'(exp_q.size()));
        foreach (exp_q[k]) begin
            if (k < log_q.size()) check(log_q[k], exp_q[k]);
        end
    endtask : cmp_log
    task automatic chk_data(input logic [23:0] r, input logic [11:0] c);
        rd_reg(REG_DATA, s);
        check(s[7:0], pat(r, c));
    endtask : chk_data
    task automatic page_read(input logic [23:0] r, input logic [11:0] c, input logic [7:0] n);
        wr_reg(REG_COL, {20'h0, c});
        wr_reg(REG_ROW, {8'h0, r});
        wr_reg(REG_COUNT, {24'h0, n});
        run(HC_PAGE_READ);
        exp_q = '{{2'b10, OP_READ}, {2'b01, c[7:0]}, {6'h10, c[11:8]}, {2'b01, r[7:0]}, {2'b01, r[15:8]},
                  {2'b01, r[23:16]}, {2'b10, OP_READ_CONF}};
        cmp_log();
        check(32'(nre), {24'h0, n});
        chk_data(r, c + 12'(n) - 12'h1);
    endtask : page_read
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #800000;
        bad_count++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h8a8ed349));
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        check({ce_n, we_n, re_n, oe_n}, 4'hf);
        // Page reads, the first ending on the last byte of the page
        for (int k = 0; k < 5; k++) begin
            cnt = 8'(1 + $urandom % 8);
            col = (k == 0) ? 12'(2112 - cnt) : 12'($urandom % 2048);
            row = 24'($urandom);
            page_read(row, col, cnt);
        end
        pc = col;
        // Repeated random column reads in the loaded page
        for (int k = 0; k < 2; k++) begin
            col = 12'($urandom % 2048);
            wr_reg(REG_COL, {20'h0, col});
            run(HC_RAND_READ);
            exp_q = '{{2'b10, OP_RAND}, {2'b01, col[7:0]}, {6'h10, col[11:8]}, {2'b10, OP_RAND_CONF}};
            cmp_log();
            chk_data(row, col + 12'(cnt) - 12'h1);
        end
        // Status polling, then read opcode again from the first column
        wr_reg(REG_COL, {20'h0, pc});
        run(HC_STATUS_POLL);
        check(log_q[log_q.size() - 1], {2'b10, OP_READ});
        chk_data(row, pc + 12'(cnt) - 12'h1);
        // Cache reads with partial readout, kept inside one block
        row = {16'($urandom), 8'h10};
        page_read(row, 12'h0, cnt);
        for (int k = 0; k < 3; k++) begin
            run(k < 2 ? HC_CACHE_NEXT : HC_CACHE_LAST);
            check(log_q[0], {2'b10, k < 2 ? OP_CACHE_NEXT : OP_CACHE_LAST});
            chk_data(row + 24'(k), 12'(cnt) - 12'h1);
        end
        // Identifier read
        run(HC_IDENT);
        exp_q = '{{2'b10, OP_IDENT}, {2'b01, 8'h00}};
        cmp_log();
        rd_reg(REG_IDENT_LO, s);
        check(s, {8'h95, 8'h90, DEVICE, MAKER});
        rd_reg(REG_IDENT_HI, s);
        check(s[7:0], 8'h54);
        // Unknown command code is refused
        log_q.delete();
        wr_reg(REG_CMD, 32'h7);
        repeat (4) @(posedge clk);
        rd_reg(REG_STATUS, s);
        check({s[ST_ERROR], s[ST_BUSY]}, 2'b10);
        check(32'(log_q.size()), 32'h0);
        complete_run();
    end
endmodule : nrs_host_bench

// file: testbench/nrs_host_properties.sv
// Checker: pin and register-port properties of the read sequencer
module nrs_host_chk
    import nrs_pkg::*;
(
    input wire logic        i_clk_sys,       // Clock
    input wire logic        i_srst,          // Reset
    input wire logic        i_rd,            // Register read strobe
    input wire logic [31:0] o_rdata,         // Register read data
    input wire logic        o_chip_en_n,     // Chip enable
    input wire logic        o_cmd_latch,     // Opcode phase
    input wire logic        o_addr_latch,    // Address phase
    input wire logic        o_write_n,       // Write pin
    input wire logic        o_read_strobe_n, // Read pin
    input wire logic [7:0]  o_io,            // Bus out
    input wire logic        o_io_oe_n,       // Bus drive enable
    input wire logic        i_ready          // Ready pin
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);
    logic [3:0] n_addr; // Address bytes since the last opcode
    logic       op_wr;  // Opcode byte on the bus
    logic       ale_zero; // Address byte of zero on the bus
    assign op_wr = !o_write_n && o_cmd_latch;
    assign ale_zero = !o_write_n && o_addr_latch && o_io == 8'h00;
    // Count address cycles between opcodes
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            n_addr <= 4'h0;
        end else if (!o_write_n) begin
            n_addr <= o_cmd_latch ? 4'h0 : n_addr + 4'h1;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_page_addr: assert property (op_wr && o_io == OP_READ_CONF |-> n_addr == PAGE_ADDR_CYC)
        else $error("page confirm not after five address bytes");
    chk_rand_addr: assert property (op_wr && o_io == OP_RAND_CONF |-> n_addr == COL_ADDR_CYC)
        else $error("random confirm not after two column bytes");
    chk_cache_ready: assert property (op_wr && (o_io == OP_CACHE_NEXT || o_io == OP_CACHE_LAST) |-> $past(i_ready))
        else $error("cache opcode while busy");
    chk_busy_wait: assert property (op_wr && o_io == OP_READ_CONF |=> o_read_strobe_n [*2])
        else $error("read strobe right after page confirm");
    chk_ident_addr: assert property (op_wr && o_io == OP_IDENT |-> ##[1:20] (ale_zero))
        else $error("identifier opcode without its address byte");
    chk_write_pulse: assert property ($fell(o_write_n) |=> $rose(o_write_n))
        else $error("write pulse not one cycle");
    chk_read_pulse: assert property ($fell(o_read_strobe_n) |=> o_read_strobe_n)
        else $error("read pulse not one cycle");
    chk_no_clash: assert property (!o_read_strobe_n |-> o_io_oe_n && o_write_n && !o_chip_en_n)
        else $error("bus driven during read strobe");
    chk_drive_write: assert property (!o_write_n |-> !o_io_oe_n && !o_chip_en_n && (o_cmd_latch != o_addr_latch))
        else $error("write cycle badly qualified");
    chk_rdata_hold: assert property (!$past(i_rd) |-> $stable(o_rdata))
        else $error("read data moved without a read");
    // Main flows seen
    cover property (op_wr && o_io == OP_CACHE_LAST);
    cover property (op_wr && o_io == OP_IDENT);
    cover property (op_wr && o_io == OP_STATUS);
endmodule : nrs_host_chk
bind nrs_host nrs_host_chk i_nrs_host_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_chip_en_n(o_chip_en_n), .o_cmd_latch(o_cmd_latch), .o_addr_latch(o_addr_latch), .o_write_n(o_write_n),
    .o_read_strobe_n(o_read_strobe_n), .o_io(o_io), .o_io_oe_n(o_io_oe_n), .i_ready(i_ready));
